// file: rtl/strap_cfg_pkg.sv
// Package for the strap-in configuration latch: codes, defaults, layouts.
// Assumes a single 20 MHz system clock domain shared by all users.
package strap_cfg_pkg;

  // Uplink interface strap codes.
  localparam logic [1:0] IFACE_MII = 2'h0;
  localparam logic [1:0] IFACE_RMII = 2'h1;
  localparam logic [1:0] IFACE_GMII = 2'h2;
  localparam logic [1:0] IFACE_RGMII = 2'h3;

  typedef enum logic [1:0] {
    uplink_mii_mode,
    uplink_rmii_mode,
    uplink_gmii_mode,
    uplink_rgmii_mode
  } uplink_mode_e;

  // Number of dual-purpose strap pins.
  localparam int STRAP_PINS = 7;

  // Bit positions inside the strap sample vector.
  localparam int SB_IFACE_LO = 0;
  localparam int SB_IFACE_HI = 1;
  localparam int SB_ROLE = 2;
  localparam int SB_REFCLK = 3;
  localparam int SB_PLL = 4;
  localparam int SB_SPEED = 5;
  localparam int SB_SDOUT = 6;

  // Strap defaults with the internal pulls left alone.
  localparam logic [6:0] STRAP_DEFAULT = 7'h3F;

  // Configuration register at offset 0x56 and its fields.
  localparam logic [7:0] CFG_REG_OFFSET = 8'h56;
  localparam int CFG_RMII_INT_BIT = 7;
  localparam int CFG_GIG_BIT = 6;
  localparam int CFG_RGMII_VER_LO = 3;
  localparam int CFG_RGMII_VER_HI = 4;
  localparam logic [7:0] CFG_RESET = 8'hC0;

  typedef struct packed {
    logic [1:0] uplink_iface;
    logic uplink_role;
    logic refclk_out;
    logic pll_source;
    logic uplink_speed;
    logic serial_dout;
  } strap_s;

  typedef struct packed {
    logic mac_role;
    logic rmii_clock_mode;
    logic rmii_normal_mode;
    logic refclk25_en;
    logic pll_from_txc;
    logic gigabit;
    logic mgmt_mdio;
  } mode_s;

endpackage

// file: rtl/strap_config_latch.sv
// Strap-in configuration latch for the switch uplink and management port.
// Assumes pins, strobes and reset are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Capture every strap pin level during reset; use it to pick modes.
// - Strap pins are pulled inputs during reset; afterwards the LED pins drive, the serial output only in SPI mode with chip select low.
// - Interface strap: 00 MII, 01 RMII, 10 GMII, 11 RGMII default.
// - In GMII or MII, role high means MAC, low means PHY.
// - PHY role drives CRS and COL; in MII also both clocks.
// - RMII with role high: clock mode, 50 MHz out on receive clock.
// - RMII with role low: normal mode, partner supplies 50 MHz reference.
// - RMII clock source set by role strap or config bit 7.
// - Reference clock strap high enables 25 MHz output, low disables.
// - In RMII normal, PLL strap low clocks PLL from transmit clock.
// - Speed strap high gives 1 Gbps in GMII or RGMII, low 10/100; register may override.
// - Serial output strap low selects SPI, high MDC/MDIO; board pull needed.
// - RGMII version bits 4:3 writable over SPI only, never MDC/MDIO.
// - In SPI mode serial output floats while chip select is high.
module strap_config_latch (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Strap pads: input, output, output enable, pull enable
  input wire logic [strap_cfg_pkg::STRAP_PINS-1:0] strap_pad_in,
  output logic [strap_cfg_pkg::STRAP_PINS-1:0] strap_pad_out,
  output logic [strap_cfg_pkg::STRAP_PINS-1:0] strap_pad_oe,
  output logic [strap_cfg_pkg::STRAP_PINS-1:0] strap_pull_en,
  // Functional drive of the pins once reset is over
  input wire logic [5:0] led_data,
  input wire logic spi_dout,
  input wire logic spi_chip_select_n,
  // Configuration register 0x56 access from the management engine
  input wire logic cfg_wr,
  input wire logic cfg_wr_from_spi,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // Decoded modes
  output strap_cfg_pkg::uplink_mode_e uplink_mode,
  output strap_cfg_pkg::mode_s modes,
  output logic [1:0] rgmii_version,
  // Uplink pin directions and clocks
  output logic crs_col_oe,
  output logic uplink_clocks_oe,
  output logic rxc_refclk50_en
);
  import strap_cfg_pkg::*;

  logic [STRAP_PINS-1:0] sample;
  logic [STRAP_PINS-1:0] func_out;
  logic [STRAP_PINS-1:0] func_oe;
  strap_s straps;
  logic loaded_q;
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic is_mii;
  logic is_rmii;
  logic is_gmii;
  logic is_rgmii;
  logic rmii_int;
  logic sdout_drive;

  // The serial output only drives in SPI mode with chip select low.
  assign sdout_drive = !sample[SB_SDOUT] && !spi_chip_select_n;
  assign func_out = {spi_dout, led_data};
  assign func_oe = {sdout_drive, {(STRAP_PINS-1){1'b1}}};

  for (genvar i = 0; i < STRAP_PINS; i++) begin : g_pin
    strap_pin_cell u_cell (
      .mclk(mclk),
      .reset(reset),
      .pad_in(strap_pad_in[i]),
      .pad_out(strap_pad_out[i]),
      .pad_oe(strap_pad_oe[i]),
      .pull_en(strap_pull_en[i]),
      .func_out(func_out[i]),
      .func_oe(func_oe[i]),
      .sample_q(sample[i])
    );
  end

  // The struct packs its fields msb first, opposite to the pin numbering,
  // so each field is picked from its own pin instead of a whole cast.
  assign straps = {
    sample[SB_IFACE_HI],
    sample[SB_IFACE_LO],
    sample[SB_ROLE],
    sample[SB_REFCLK],
    sample[SB_PLL],
    sample[SB_SPEED],
    sample[SB_SDOUT]
  };
  assign is_mii = straps.uplink_iface == IFACE_MII;
  assign is_rmii = straps.uplink_iface == IFACE_RMII;
  assign is_gmii = straps.uplink_iface == IFACE_GMII;
  assign is_rgmii = straps.uplink_iface == IFACE_RGMII;
  assign rmii_int = cfg_q[CFG_RMII_INT_BIT];

  // Register bits 7 and 6 follow the straps until software writes them.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= 1'b1;
    end
  end

  always_comb begin
    cfg_d = cfg_q;
    if (!loaded_q) begin
      cfg_d[CFG_RMII_INT_BIT] = straps.uplink_role;
      cfg_d[CFG_GIG_BIT] = straps.uplink_speed;
    end else if (cfg_wr) begin
      cfg_d[CFG_RMII_INT_BIT] = cfg_wdata[CFG_RMII_INT_BIT];
      cfg_d[CFG_GIG_BIT] = cfg_wdata[CFG_GIG_BIT];
      // The bits around the version field are plain storage.
      cfg_d[CFG_RGMII_VER_HI+1] = cfg_wdata[CFG_RGMII_VER_HI+1];
      cfg_d[CFG_RGMII_VER_LO-1:0] = cfg_wdata[CFG_RGMII_VER_LO-1:0];
      // MDC/MDIO writes cannot reach the RGMII version field.
      if (cfg_wr_from_spi) begin
        cfg_d[CFG_RGMII_VER_HI:CFG_RGMII_VER_LO] =
          cfg_wdata[CFG_RGMII_VER_HI:CFG_RGMII_VER_LO];
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg_q <= CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg_rdata <= CFG_RESET;
      rgmii_version <= CFG_RESET[CFG_RGMII_VER_HI:CFG_RGMII_VER_LO];
    end else begin
      cfg_rdata <= cfg_q;
      rgmii_version <= cfg_q[CFG_RGMII_VER_HI:CFG_RGMII_VER_LO];
    end
  end

  // Decoded modes are registered so every output leaves a flip-flop.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      uplink_mode <= uplink_rgmii_mode;
      modes <= '0;
    end else begin
      uplink_mode <= uplink_mode_e'(straps.uplink_iface);
      modes.mac_role <= straps.uplink_role;
      modes.rmii_clock_mode <= is_rmii && rmii_int;
      modes.rmii_normal_mode <= is_rmii && !rmii_int;
      modes.refclk25_en <= straps.refclk_out;
      modes.pll_from_txc <= is_rmii && !rmii_int &&
        !straps.pll_source;
      modes.gigabit <= (is_gmii || is_rgmii) &&
        cfg_q[CFG_GIG_BIT];
      modes.mgmt_mdio <= straps.serial_dout;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      crs_col_oe <= 1'b0;
      uplink_clocks_oe <= 1'b0;
      rxc_refclk50_en <= 1'b0;
    end else begin
      crs_col_oe <= (is_gmii || is_mii) && !straps.uplink_role;
      uplink_clocks_oe <= is_mii && !straps.uplink_role;
      // In RMII normal mode the partner owns the reference clock.
      rxc_refclk50_en <= is_rmii && rmii_int;
    end
  end

  a_iface_decode: assert property (@(posedge mclk)
    disable iff (reset)
    loaded_q |=> uplink_mode == uplink_mode_e'($past(straps.uplink_iface)))
    else $error("uplink mode does not follow interface strap");

  a_role_select: assert property (@(posedge mclk)
    disable iff (reset)
    loaded_q |=> modes.mac_role == $past(straps.uplink_role))
    else $error("uplink role does not follow role strap");

  a_phy_pins_out: assert property (@(posedge mclk)
    disable iff (reset)
    (is_mii && !straps.uplink_role) |=> crs_col_oe && uplink_clocks_oe)
    else $error("MII PHY role did not drive CRS, COL and clocks");

  a_gmii_phy_pins: assert property (@(posedge mclk)
    disable iff (reset)
    (is_gmii && !straps.uplink_role) |=> crs_col_oe && !uplink_clocks_oe)
    else $error("GMII PHY role pin directions wrong");

  a_mac_pins_in: assert property (@(posedge mclk)
    disable iff (reset)
    straps.uplink_role |=> !crs_col_oe && !uplink_clocks_oe)
    else $error("MAC role drove CRS, COL or clocks");

  a_rmii_clock_out: assert property (@(posedge mclk)
    disable iff (reset)
    (is_rmii && rmii_int) |=> rxc_refclk50_en && modes.rmii_clock_mode)
    else $error("RMII clock mode did not drive the 50 MHz clock");

  a_rmii_normal: assert property (@(posedge mclk)
    disable iff (reset)
    (is_rmii && !rmii_int) |=> !rxc_refclk50_en && modes.rmii_normal_mode)
    else $error("RMII normal mode drove the reference clock");

  a_rmii_off: assert property (@(posedge mclk)
    disable iff (reset)
    !is_rmii |=> !rxc_refclk50_en && !modes.rmii_clock_mode &&
      !modes.rmii_normal_mode && !modes.pll_from_txc)
    else $error("RMII clocking active outside RMII mode");

  a_rmii_src_mirror: assert property (@(posedge mclk)
    disable iff (reset)
    !loaded_q |=> cfg_q[CFG_RMII_INT_BIT] == straps.uplink_role)
    else $error("RMII clock bit did not mirror role strap");

  a_refclk_enable: assert property (@(posedge mclk)
    disable iff (reset)
    loaded_q |=> modes.refclk25_en == $past(straps.refclk_out))
    else $error("reference clock enable does not follow strap");

  a_pll_source: assert property (@(posedge mclk)
    disable iff (reset)
    modes.pll_from_txc |-> $past(is_rmii && !rmii_int && !straps.pll_source))
    else $error("PLL taken from transmit clock outside RMII normal");

  a_pll_crystal: assert property (@(posedge mclk)
    disable iff (reset)
    (is_rmii && !rmii_int && straps.pll_source) |=> !modes.pll_from_txc)
    else $error("PLL left the crystal with source strap high");

  a_gig_select: assert property (@(posedge mclk)
    disable iff (reset)
    modes.gigabit |-> $past(cfg_q[CFG_GIG_BIT]) && $past(is_gmii || is_rgmii))
    else $error("gigabit set without speed select");

  a_speed_low: assert property (@(posedge mclk)
    disable iff (reset)
    !cfg_q[CFG_GIG_BIT] |=> !modes.gigabit)
    else $error("gigabit set while speed bit is low");

  a_speed_mirror: assert property (@(posedge mclk)
    disable iff (reset)
    !loaded_q |=> cfg_q[CFG_GIG_BIT] == straps.uplink_speed)
    else $error("speed bit did not mirror speed strap");

  a_mgmt_select: assert property (@(posedge mclk)
    disable iff (reset)
    loaded_q |=> modes.mgmt_mdio == $past(straps.serial_dout))
    else $error("management bus does not follow serial strap");

  a_mdio_quiet: assert property (@(posedge mclk)
    disable iff (reset)
    (straps.serial_dout && loaded_q) |=> !strap_pad_oe[SB_SDOUT])
    else $error("serial output driven in MDC/MDIO mode");

  a_rgmii_ver_guard: assert property (@(posedge mclk)
    disable iff (reset)
    (loaded_q && cfg_wr && !cfg_wr_from_spi) |=>
      $stable(cfg_q[CFG_RGMII_VER_HI:CFG_RGMII_VER_LO]))
    else $error("RGMII version changed by a non-SPI write");

  a_rgmii_ver_spi: assert property (@(posedge mclk)
    disable iff (reset)
    (loaded_q && cfg_wr && cfg_wr_from_spi) |=>
      cfg_q[CFG_RGMII_VER_HI:CFG_RGMII_VER_LO] ==
      $past(cfg_wdata[CFG_RGMII_VER_HI:CFG_RGMII_VER_LO]))
    else $error("SPI write did not set the RGMII version");

  a_rgmii_ver_out: assert property (@(posedge mclk)
    disable iff (reset)
    loaded_q |=> rgmii_version ==
      $past(cfg_q[CFG_RGMII_VER_HI:CFG_RGMII_VER_LO]))
    else $error("RGMII version output does not follow register");

  a_sdout_float: assert property (@(posedge mclk)
    disable iff (reset)
    (spi_chip_select_n && loaded_q) |=> !strap_pad_oe[SB_SDOUT])
    else $error("serial output driven while deselected");

  a_sdout_drive: assert property (@(posedge mclk)
    disable iff (reset)
    (!spi_chip_select_n && !straps.serial_dout && loaded_q) |=>
      strap_pad_oe[SB_SDOUT])
    else $error("serial output not driven while selected");

  a_modes_hold: assert property (@(posedge mclk)
    disable iff (reset)
    (loaded_q && $past(loaded_q)) |-> $stable(uplink_mode) &&
      $stable(modes.mac_role) && $stable(modes.refclk25_en) &&
      $stable(modes.mgmt_mdio))
    else $error("strap-driven mode changed after reset");

  a_rdata_follow: assert property (@(posedge mclk)
    disable iff (reset)
    loaded_q |=> cfg_rdata == $past(cfg_q))
    else $error("read data does not follow the config register");

  a_pulls_released: assert property (@(posedge mclk)
    disable iff (reset)
    loaded_q |-> strap_pull_en == '0 &&
      strap_pad_oe[SB_SDOUT-1:0] == '1)
    else $error("LED strap pins not driven after reset");

endmodule // strap_config_latch
`default_nettype wire

// file: rtl/strap_pin_cell.sv
// One dual-purpose strap pin: sampled input during reset, output after.
// Assumes the pad applies its pull while pull_en is high.
`timescale 1ns/1ps
`default_nettype none
module strap_pin_cell (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pull_en,
  // Function side
  input wire logic func_out,
  input wire logic func_oe,
  output logic sample_q
);

  // Sampled on every edge while reset is high; holds after release.
  always_ff @(posedge mclk) begin
    if (reset) begin
      sample_q <= pad_in;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pad_oe <= 1'b0;
      pad_out <= 1'b0;
      pull_en <= 1'b1;
    end else begin
      pad_oe <= func_oe;
      pad_out <= func_out;
      pull_en <= 1'b0;
    end
  end

  a_pin_input_rst: assert property (@(posedge mclk) disable iff (reset)
    $past(reset) |-> !pad_oe && pull_en)
    else $error("strap pin drove while reset was active");

  a_sample_held: assert property (@(posedge mclk) disable iff (reset)
    !$past(reset) |-> $stable(sample_q))
    else $error("strap sample changed outside reset");

endmodule // strap_pin_cell
`default_nettype wire

// file: test/strap_config_latch_bench.sv
// Bench for the strap configuration latch: decode, pins and config writes.
// Assumes the pull model supplies the board resistors on every strap pin.
`timescale 1ns/1ps
`default_nettype none
module strap_config_latch_bench;
  import strap_cfg_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [6:0] strap_lvl = STRAP_DEFAULT;
  logic [6:0] pad_in, pad_out, pad_oe, pull_en;
  logic [5:0] led_data = 6'h00;
  logic spi_dout = 1'b0;
  logic cs_n = 1'b1;
  logic cfg_wr = 1'b0;
  logic cfg_spi = 1'b0;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata;
  uplink_mode_e uplink_mode;
  mode_s modes;
  logic [1:0] rgmii_version;
  logic crs_col_oe, uplink_clocks_oe, rxc_refclk50_en;
  int bad_count = 0;
  int tests_run = 0;
  logic [6:0] tbl [7] = '{7'h3F, 7'h38, 7'h3A, 7'h1D, 7'h61, 7'h06, 7'h04};

  always #25 mclk = ~mclk;

  strap_pull_model pulls (.strap_level(strap_lvl), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_in(pad_in));

  strap_config_latch DUT (.mclk(mclk), .reset(reset),
    .strap_pad_in(pad_in), .strap_pad_out(pad_out), .strap_pad_oe(pad_oe),
    .strap_pull_en(pull_en), .led_data(led_data), .spi_dout(spi_dout),
    .spi_chip_select_n(cs_n), .cfg_wr(cfg_wr), .cfg_wr_from_spi(cfg_spi),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .uplink_mode(uplink_mode),
    .modes(modes), .rgmii_version(rgmii_version), .crs_col_oe(crs_col_oe),
    .uplink_clocks_oe(uplink_clocks_oe), .rxc_refclk50_en(rxc_refclk50_en));

  task automatic close_out;
    $display("mismatches %0d, comparisons %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic step;
    @(posedge mclk);
    #1;
  endtask

  // Two edges with reset high, then two edges for the decode to settle.
  task automatic do_reset(input logic [6:0] s);
    strap_lvl = s;
    reset = 1'b1;
    step;
    step;
    chk8({1'h0, pull_en}, 8'h7F);
    chk8({1'h0, pad_oe}, 8'h00);
    reset = 1'b0;
    step;
    step;
  endtask

  task automatic check_straps(input logic [6:0] s);
    logic mg, rm, gig;
    mg = (s[1:0] == IFACE_MII) || (s[1:0] == IFACE_GMII);
    rm = (s[1:0] == IFACE_RMII);
    gig = (s[1:0] == IFACE_GMII) || (s[1:0] == IFACE_RGMII);
    chk8({6'h00, uplink_mode}, {6'h00, s[1:0]});
    chk1(modes.refclk25_en, s[3]);
    chk1(modes.mgmt_mdio, s[6]);
    chk8(cfg_rdata, {s[2], s[5], 6'h00});
    chk1(modes.gigabit, gig && s[5]);
    chk1(crs_col_oe, mg && !s[2]);
    chk1(uplink_clocks_oe, !s[2] && s[1:0] == IFACE_MII);
    chk1(modes.rmii_clock_mode, rm && s[2]);
    chk1(rxc_refclk50_en, rm && s[2]);
    chk1(modes.rmii_normal_mode, rm && !s[2]);
    chk1(modes.pll_from_txc, rm && !s[2] && !s[4]);
    if (mg) begin
      chk1(modes.mac_role, s[2]);
    end
  endtask

  task automatic scen_straps;
    for (int i = 0; i < 7; i++) begin
      do_reset(tbl[i]);
      check_straps(tbl[i]);
    end
  endtask

  task automatic scen_pins;
    do_reset(STRAP_DEFAULT);
    led_data = 6'h2A;
    step;
    chk8({2'h0, pad_out[5:0]}, 8'h2A);
    chk8({2'h0, pad_oe[5:0]}, 8'h3F);
    chk8({1'h0, pull_en}, 8'h00);
    led_data = 6'h15;
    step;
    chk8({2'h0, pad_out[5:0]}, 8'h15);
    step;
    check_straps(STRAP_DEFAULT);
  endtask

  task automatic scen_spi;
    do_reset(7'h3F);
    spi_dout = 1'b1;
    step;
    chk1(pad_oe[6], 1'b0);
    cs_n = 1'b0;
    step;
    chk1(pad_oe[6], 1'b1);
    chk1(pad_out[6], 1'b1);
    cs_n = 1'b1;
    step;
    chk1(pad_oe[6], 1'b0);
    do_reset(7'h7F);
    cs_n = 1'b0;
    step;
    chk1(pad_oe[6], 1'b0);
    cs_n = 1'b1;
  endtask

  // The host writes the config byte; the result shows two edges later.
  task automatic cfg_write(input logic [7:0] d, input logic spi);
    cfg_wr = 1'b1;
    cfg_wdata = d;
    cfg_spi = spi;
    step;
    cfg_wr = 1'b0;
    step;
    step;
  endtask

  task automatic scen_cfg;
    do_reset(7'h1D);
    cfg_write(8'h18, 1'b1);
    chk8(cfg_rdata, 8'h18);
    chk8({6'h00, rgmii_version}, 8'h03);
    chk1(modes.rmii_clock_mode, 1'b0);
    chk1(modes.rmii_normal_mode, 1'b1);
    chk1(rxc_refclk50_en, 1'b0);
    cfg_write(8'hC7, 1'b0);
    chk8(cfg_rdata, 8'hDF);
    chk8({6'h00, rgmii_version}, 8'h03);
    chk1(modes.rmii_clock_mode, 1'b1);
    do_reset(STRAP_DEFAULT);
    cfg_write(8'h00, 1'b1);
    chk1(modes.gigabit, 1'b0);
    cfg_write(8'h40, 1'b1);
    chk1(modes.gigabit, 1'b1);
  endtask

  // The whole run needs under a hundred cycles; this limit is far above it.
  initial begin
    #100000;
    bad_count++;
    close_out;
  end

  initial begin
    scen_straps;
    scen_pins;
    scen_spi;
    scen_cfg;
    close_out;
  end
endmodule // strap_config_latch_bench
`default_nettype wire

// file: test/strap_pull_model.sv
// Board side of the strap pins: external pull resistors on every pin.
// Assumes the bench sets the resistor pattern before each reset.
`timescale 1ns/1ps
`default_nettype none
module strap_pull_model (
  // Resistor pattern fitted on the board
  input wire logic [6:0] strap_level,
  // Device pad drive
  input wire logic [6:0] pad_out,
  input wire logic [6:0] pad_oe,
  // Resolved pad level
  output logic [6:0] pad_in
);
  // The external resistor outweighs the weak internal pull, so an undriven
  // pin always reads the fitted level; a driving device wins over both.
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & strap_level);
endmodule // strap_pull_model
`default_nettype wire
